// *** rtl/sdc_pkg.sv ***
// shared constants and carrier types for the demodulator control block
`default_nettype none
package sdc_pkg;
    // register byte offsets on the 32-bit bus
    localparam logic [11:0] OFS_LED_CFG    = 12'h000;
    localparam logic [11:0] OFS_SC_CFG     = 12'h070;
    localparam logic [11:0] OFS_SEQ_COUNT  = 12'h080;
    localparam logic [11:0] OFS_CONV_COUNT = 12'h084;
    localparam logic [11:0] OFS_EAF_CFG    = 12'h090;

    // signal_conditioning_config field positions
    localparam int SC_POL_BIT       = 26;
    localparam int SC_AA_LSB        = 24;
    localparam int SC_SUBS_LSB      = 13;
    localparam int SC_LP_LSB        = 11;
    localparam int SC_HP_PWR_BIT    = 10;
    localparam int SC_HP_SKIP_BIT   = 9;
    localparam int SC_HP_LSB        = 7;
    localparam int SC_DM_PWR_BIT    = 6;
    localparam int SC_DM_SKIP_BIT   = 5;
    localparam int SC_GAIN_PWR_BIT  = 4;
    localparam int SC_GAIN_SKIP_BIT = 3;
    localparam int SC_GAIN_LSB      = 0;
    // led_analog_config and electrical_frontend_config bits
    localparam int LED_SIGREF_BIT   = 18;
    localparam int EAF_REF_DAC_BIT  = 25;
    localparam int EAF_MEAS_DAC_BIT = 24;
    // sequencer counter register: subsample count position
    localparam int SEQ_SUBS_LSB     = 24;

    // implemented bits per register, the rest read zero
    localparam logic [31:0] LED_MASK = 32'h0004_0000;
    localparam logic [31:0] SC_MASK  = 32'h071F_FFFF;
    localparam logic [31:0] EAF_MASK = 32'h0307_FFFF;
    // reset values
    localparam logic [31:0] LED_RST  = 32'h0000_0000;
    localparam logic [31:0] SC_RST   = 32'h0000_0000;
    localparam logic [31:0] EAF_RST  = 32'h0000_0000;
    localparam logic [7:0]  CNT_RST  = 8'h00;
    // forbidden gain code
    localparam logic [2:0]  GAIN_FORBIDDEN = 3'h7;
    // bus responses
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    // demodulator multiplication factor
    typedef enum logic [1:0] {
        SDC_FACTOR_ZERO,
        SDC_FACTOR_POS,
        SDC_FACTOR_NEG
    } sdc_factor_t;

    // one multiplication window in sequencer ticks
    typedef struct packed {
        logic [15:0] begin_time;
        logic [15:0] end_time;
    } sdc_window_t;

    // sequencer time base as seen by this block
    typedef struct packed {
        logic        running;
        logic        iter_start;
        logic [15:0] time_now;
        sdc_window_t positive_window;
        sdc_window_t negative_window1;
        sdc_window_t negative_window2;
    } sdc_seq_t;

    // static settings for the analog chain
    typedef struct packed {
        logic [1:0] antialias_cutoff_select;
        logic [1:0] demod_lowpass_select;
        logic       highpass_power;
        logic       highpass_skip;
        logic [1:0] highpass_cutoff_select;
        logic       demod_power;
        logic       demod_skip;
        logic       gain_power;
        logic       gain_skip;
        logic [2:0] gain_code;
        logic       sigref_enable;
        logic       sigref_on_dac_buffer;
        logic       measure_dac;
    } sdc_cond_cfg_t;
endpackage : sdc_pkg
`default_nettype wire

// *** rtl/sdc_window_cmp.sv ***
// window comparator: is the sequencer time inside one window
`default_nettype none
module sdc_window_cmp (
    input  wire logic [15:0]         i_time,
    input  wire sdc_pkg::sdc_window_t i_window,
    output logic                     o_active
);
    // begin inclusive, end exclusive so back-to-back windows never overlap
    always_comb begin
        o_active = (i_time >= i_window.begin_time) &&
                   (i_time <  i_window.end_time);
    end
endmodule : sdc_window_cmp
`default_nettype wire

// *** rtl/sdc_ctrl.sv ***
// demodulator timing, subsampling and conditioning registers, axi4-lite
// How it works
// RL1 - read-only 8-bit conversion count, reset zero
// RL2 - demodulator only acts while sequencer runs
// RL3 - factor plus, zero or minus from windows
// RL4 - software sets initial polarity by first window
// RL5 - ratio N skips N iterations, then converts
// RL6 - software prefers conversion-done interrupt when subsampling
// RL7 - two-bit anti-alias cutoff select, default zero
// RL8 - two-bit demodulator low pass select, default zero
// RL9 - high pass power and skip bits
// RL10 - two-bit high pass cutoff select, default zero
// RL11 - demodulator power and skip bits
// RL12 - gain power, skip, gain code seven refused
// RL13 - signal reference enable bit, set before analog
// RL14 - reference node to dac buffer bit
// RL15 - dac output to gain-stage input bit
// RL16 - one positive, two negative windows from sequencer
// RL17 - subsample counter readable in counter register
// RL18 - subsample counter clears at sequencer start
`default_nettype none
module sdc_ctrl (
    input  wire logic                 i_clock,
    input  wire logic                 i_reset,
    // axi4-lite slave
    input  wire logic                 i_axi_awvalid,
    output logic                      o_axi_awready,
    input  wire logic [11:0]          i_axi_awaddr,
    input  wire logic [2:0]           i_axi_awprot,
    input  wire logic                 i_axi_wvalid,
    output logic                      o_axi_wready,
    input  wire logic [31:0]          i_axi_wdata,
    input  wire logic [3:0]           i_axi_wstrb,
    output logic                      o_axi_bvalid,
    input  wire logic                 i_axi_bready,
    output logic [1:0]                o_axi_bresp,
    input  wire logic                 i_axi_arvalid,
    output logic                      o_axi_arready,
    input  wire logic [11:0]          i_axi_araddr,
    input  wire logic [2:0]           i_axi_arprot,
    output logic                      o_axi_rvalid,
    input  wire logic                 i_axi_rready,
    output logic [31:0]               o_axi_rdata,
    output logic [1:0]                o_axi_rresp,
    // sequencer time base and converter events
    input  wire sdc_pkg::sdc_seq_t    i_seq,
    input  wire logic                 i_adc_done,
    // outputs to the analog chain and converter
    output sdc_pkg::sdc_factor_t      o_demod_factor,
    output logic                      o_adc_allow,
    output sdc_pkg::sdc_cond_cfg_t    o_cond_cfg
);
    // protection bits carry no meaning here
    logic unused_prot;
    assign unused_prot = ^{i_axi_awprot, i_axi_arprot};

    // register file state
    logic [31:0] led_cfg_ff, nxt_led_cfg;    // led_analog_config
    logic [31:0] sc_cfg_ff, nxt_sc_cfg;      // signal_conditioning_config
    logic [31:0] eaf_cfg_ff, nxt_eaf_cfg;    // electrical_frontend_config
    // write channel holding state
    logic        aw_held_ff, nxt_aw_held;
    logic [11:0] aw_addr_ff, nxt_aw_addr;
    logic        w_held_ff, nxt_w_held;
    logic [31:0] w_data_ff, nxt_w_data;
    logic [3:0]  w_strb_ff, nxt_w_strb;
    logic        bvalid_ff, nxt_bvalid;
    logic [1:0]  bresp_ff, nxt_bresp;
    // read channel state
    logic        rvalid_ff, nxt_rvalid;
    logic [31:0] rdata_ff, nxt_rdata;
    logic [1:0]  rresp_ff, nxt_rresp;
    // sequencer side state
    logic        running_q_ff, nxt_running_q;
    logic [7:0]  subs_cnt_ff, nxt_subs_cnt;
    logic        allow_ff, nxt_allow;
    logic [7:0]  conv_cnt_ff, nxt_conv_cnt;
    sdc_pkg::sdc_factor_t factor_ff, nxt_factor;

    // working signals
    logic        aw_have, w_have, do_write;
    logic [11:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic        seq_start;
    logic [7:0]  demod_subsample_ratio;
    logic [2:0]  win_active;                 // pos, neg1, neg2

    // byte-lane merge limited to implemented bits
    function automatic logic [31:0] merge_lanes(input logic [31:0] old_val,
                                                input logic [31:0] new_val,
                                                input logic [3:0]  strb,
                                                input logic [31:0] mask);
        logic [31:0] lanes;
        lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        return ((old_val & ~lanes) | (new_val & lanes)) & mask;
    endfunction : merge_lanes

    // three window comparators, one per multiplication window
    sdc_window_cmp u_win_pos (                                        // RL16
        .i_time   (i_seq.time_now),
        .i_window (i_seq.positive_window),
        .o_active (win_active[0])
    );
    sdc_window_cmp u_win_neg1 (                                       // RL16
        .i_time   (i_seq.time_now),
        .i_window (i_seq.negative_window1),
        .o_active (win_active[1])
    );
    sdc_window_cmp u_win_neg2 (                                       // RL16
        .i_time   (i_seq.time_now),
        .i_window (i_seq.negative_window2),
        .o_active (win_active[2])
    );

    // write channel: address and data taken in either order
    assign o_axi_awready = !aw_held_ff && !bvalid_ff;
    assign o_axi_wready  = !w_held_ff && !bvalid_ff;
    assign aw_have  = aw_held_ff || (i_axi_awvalid && o_axi_awready);
    assign w_have   = w_held_ff || (i_axi_wvalid && o_axi_wready);
    assign do_write = aw_have && w_have && !bvalid_ff;
    assign wr_addr  = aw_held_ff ? aw_addr_ff : i_axi_awaddr;
    assign wr_data  = w_held_ff ? w_data_ff : i_axi_wdata;
    assign wr_strb  = w_held_ff ? w_strb_ff : i_axi_wstrb;

    // next state of write channel and writable registers
    always_comb begin
        nxt_aw_held = aw_held_ff;
        nxt_aw_addr = aw_addr_ff;
        nxt_w_held  = w_held_ff;
        nxt_w_data  = w_data_ff;
        nxt_w_strb  = w_strb_ff;
        nxt_bvalid  = bvalid_ff;
        nxt_bresp   = bresp_ff;
        nxt_led_cfg = led_cfg_ff;
        nxt_sc_cfg  = sc_cfg_ff;
        nxt_eaf_cfg = eaf_cfg_ff;
        if (bvalid_ff && i_axi_bready) begin
            nxt_bvalid = 1'b0;
        end
        if (do_write) begin
            // both halves present: commit and answer next cycle
            nxt_aw_held = 1'b0;
            nxt_w_held  = 1'b0;
            nxt_bvalid  = 1'b1;
            nxt_bresp   = sdc_pkg::RESP_OKAY;
            unique case (wr_addr)
                sdc_pkg::OFS_LED_CFG: begin                        // RL13
                    nxt_led_cfg = merge_lanes(led_cfg_ff, wr_data, wr_strb,
                                              sdc_pkg::LED_MASK);
                end
                sdc_pkg::OFS_SC_CFG: begin
                    nxt_sc_cfg = merge_lanes(sc_cfg_ff, wr_data, wr_strb,
                                             sdc_pkg::SC_MASK);
                    // forbidden gain keeps the previous gain
                    if (nxt_sc_cfg[sdc_pkg::SC_GAIN_LSB +: 3] ==
                        sdc_pkg::GAIN_FORBIDDEN) begin                 // RL12
                        nxt_sc_cfg[sdc_pkg::SC_GAIN_LSB +: 3] =
                            sc_cfg_ff[sdc_pkg::SC_GAIN_LSB +: 3];
                    end
                end
                sdc_pkg::OFS_EAF_CFG: begin                        // RL14
                    nxt_eaf_cfg = merge_lanes(eaf_cfg_ff, wr_data, wr_strb,
                                              sdc_pkg::EAF_MASK);
                end
                // read-only counters take writes silently
                sdc_pkg::OFS_SEQ_COUNT, sdc_pkg::OFS_CONV_COUNT: begin
                    nxt_bresp = sdc_pkg::RESP_OKAY;
                end
                default: begin
                    nxt_bresp = sdc_pkg::RESP_SLVERR;
                end
            endcase
        end else begin
            // park whichever half arrived first
            if (i_axi_awvalid && o_axi_awready) begin
                nxt_aw_held = 1'b1;
                nxt_aw_addr = i_axi_awaddr;
            end
            if (i_axi_wvalid && o_axi_wready) begin
                nxt_w_held = 1'b1;
                nxt_w_data = i_axi_wdata;
                nxt_w_strb = i_axi_wstrb;
            end
        end
    end

    // read channel: one read under way, data from a flop
    assign o_axi_arready = !rvalid_ff;
    always_comb begin
        nxt_rvalid = rvalid_ff;
        nxt_rdata  = rdata_ff;
        nxt_rresp  = rresp_ff;
        if (rvalid_ff && i_axi_rready) begin
            nxt_rvalid = 1'b0;
        end
        if (i_axi_arvalid && o_axi_arready) begin
            nxt_rvalid = 1'b1;
            nxt_rresp  = sdc_pkg::RESP_OKAY;
            nxt_rdata  = 32'h0000_0000;
            unique case (i_axi_araddr)
                sdc_pkg::OFS_LED_CFG:    nxt_rdata = led_cfg_ff;
                sdc_pkg::OFS_SC_CFG:     nxt_rdata = sc_cfg_ff;
                sdc_pkg::OFS_EAF_CFG:    nxt_rdata = eaf_cfg_ff;
                sdc_pkg::OFS_SEQ_COUNT: begin                      // RL17
                    nxt_rdata[sdc_pkg::SEQ_SUBS_LSB +: 8] = subs_cnt_ff;
                end
                sdc_pkg::OFS_CONV_COUNT: begin                     // RL1
                    nxt_rdata[7:0] = conv_cnt_ff;
                end
                default: begin
                    nxt_rresp = sdc_pkg::RESP_SLVERR;
                end
            endcase
        end
    end

    // bus-facing flops
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            led_cfg_ff <= sdc_pkg::LED_RST;
            sc_cfg_ff  <= sdc_pkg::SC_RST;
            eaf_cfg_ff <= sdc_pkg::EAF_RST;
            aw_held_ff <= 1'b0;
            aw_addr_ff <= 12'h000;
            w_held_ff  <= 1'b0;
            w_data_ff  <= 32'h0000_0000;
            w_strb_ff  <= 4'h0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= sdc_pkg::RESP_OKAY;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= 32'h0000_0000;
            rresp_ff   <= sdc_pkg::RESP_OKAY;
        end else begin
            led_cfg_ff <= nxt_led_cfg;
            sc_cfg_ff  <= nxt_sc_cfg;
            eaf_cfg_ff <= nxt_eaf_cfg;
            aw_held_ff <= nxt_aw_held;
            aw_addr_ff <= nxt_aw_addr;
            w_held_ff  <= nxt_w_held;
            w_data_ff  <= nxt_w_data;
            w_strb_ff  <= nxt_w_strb;
            bvalid_ff  <= nxt_bvalid;
            bresp_ff   <= nxt_bresp;
            rvalid_ff  <= nxt_rvalid;
            rdata_ff   <= nxt_rdata;
            rresp_ff   <= nxt_rresp;
        end
    end

    assign o_axi_bvalid = bvalid_ff;
    assign o_axi_bresp  = bresp_ff;
    assign o_axi_rvalid = rvalid_ff;
    assign o_axi_rdata  = rdata_ff;
    assign o_axi_rresp  = rresp_ff;

    // settings straight from the register flops
    assign demod_subsample_ratio = sc_cfg_ff[sdc_pkg::SC_SUBS_LSB +: 8];
    always_comb begin
        o_cond_cfg.antialias_cutoff_select =
            sc_cfg_ff[sdc_pkg::SC_AA_LSB +: 2];                        // RL7
        o_cond_cfg.demod_lowpass_select =
            sc_cfg_ff[sdc_pkg::SC_LP_LSB +: 2];                        // RL8
        o_cond_cfg.highpass_power = sc_cfg_ff[sdc_pkg::SC_HP_PWR_BIT]; // RL9
        o_cond_cfg.highpass_skip = sc_cfg_ff[sdc_pkg::SC_HP_SKIP_BIT]; // RL9
        o_cond_cfg.highpass_cutoff_select =
            sc_cfg_ff[sdc_pkg::SC_HP_LSB +: 2];                        // RL10
        o_cond_cfg.demod_power = sc_cfg_ff[sdc_pkg::SC_DM_PWR_BIT];    // RL11
        o_cond_cfg.demod_skip = sc_cfg_ff[sdc_pkg::SC_DM_SKIP_BIT];    // RL11
        o_cond_cfg.gain_power = sc_cfg_ff[sdc_pkg::SC_GAIN_PWR_BIT];   // RL12
        o_cond_cfg.gain_skip = sc_cfg_ff[sdc_pkg::SC_GAIN_SKIP_BIT];   // RL12
        o_cond_cfg.gain_code = sc_cfg_ff[sdc_pkg::SC_GAIN_LSB +: 3];   // RL12
        o_cond_cfg.sigref_enable = led_cfg_ff[sdc_pkg::LED_SIGREF_BIT];// RL13
        o_cond_cfg.sigref_on_dac_buffer =
            eaf_cfg_ff[sdc_pkg::EAF_REF_DAC_BIT];                      // RL14
        o_cond_cfg.measure_dac = eaf_cfg_ff[sdc_pkg::EAF_MEAS_DAC_BIT];// RL15
    end

    // subsampling, conversion count and demodulator factor
    assign seq_start = i_seq.running && !running_q_ff;
    always_comb begin
        logic [7:0] cnt_base;
        logic       dm_on;
        logic       pos_on;
        logic       neg_on;
        cnt_base      = seq_start ? 8'h00 : subs_cnt_ff;           // RL18
        dm_on         = 1'b0;
        pos_on        = win_active[0];
        neg_on        = win_active[1] || win_active[2];
        nxt_running_q = i_seq.running;
        nxt_subs_cnt  = cnt_base;
        nxt_allow     = allow_ff;
        // a done pulse always counts, wrapping at 8 bits
        nxt_conv_cnt  = i_adc_done ? conv_cnt_ff + 8'h01
                                   : conv_cnt_ff;                  // RL1
        if (!i_seq.running) begin
            nxt_allow = 1'b0;
        end else if (i_seq.iter_start) begin
            // decide once per iteration, held until the next one or until the sequencer stops
            if (cnt_base == demod_subsample_ratio) begin           // RL5
                nxt_allow    = 1'b1;
                nxt_subs_cnt = 8'h00;
            end else begin
                nxt_allow    = 1'b0;
                nxt_subs_cnt = cnt_base + 8'h01;
            end
        end
        // switching only makes sense locked to a running sequencer
        dm_on = i_seq.running && o_cond_cfg.demod_power &&
                !o_cond_cfg.demod_skip;                            // RL2
        if (!dm_on) begin
            nxt_factor = sdc_pkg::SDC_FACTOR_ZERO;
        end else if (pos_on && neg_on) begin
            // overlap: the polarity bit picks the winner, set gives plus, clear gives minus
            nxt_factor = sc_cfg_ff[sdc_pkg::SC_POL_BIT] ?
                         sdc_pkg::SDC_FACTOR_POS :
                         sdc_pkg::SDC_FACTOR_NEG;                  // RL4
        end else if (pos_on) begin
            nxt_factor = sdc_pkg::SDC_FACTOR_POS;                  // RL3
        end else if (neg_on) begin
            nxt_factor = sdc_pkg::SDC_FACTOR_NEG;                  // RL3
        end else begin
            nxt_factor = sdc_pkg::SDC_FACTOR_ZERO;                 // RL3
        end
    end

    // sequencer-side flops
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            running_q_ff <= 1'b0;
            subs_cnt_ff  <= 8'h00;
            allow_ff     <= 1'b0;
            conv_cnt_ff  <= sdc_pkg::CNT_RST;
            factor_ff    <= sdc_pkg::SDC_FACTOR_ZERO;
        end else begin
            running_q_ff <= nxt_running_q;
            subs_cnt_ff  <= nxt_subs_cnt;
            allow_ff     <= nxt_allow;
            conv_cnt_ff  <= nxt_conv_cnt;
            factor_ff    <= nxt_factor;
        end
    end

    assign o_adc_allow    = allow_ff;
    assign o_demod_factor = factor_ff;

    // checks
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_reset);

    property p_conv_count;
        i_adc_done |=> conv_cnt_ff == $past(conv_cnt_ff) + 8'h01;
    endproperty
    a_conv_count: assert property (p_conv_count) // RL1
        else $error("conversion count did not advance");

    property p_idle_zero;
        !i_seq.running |=> o_demod_factor == sdc_pkg::SDC_FACTOR_ZERO;
    endproperty
    a_idle_zero: assert property (p_idle_zero) // RL2
        else $error("factor nonzero while sequencer stopped");

    property p_pos_factor;
        (i_seq.running && o_cond_cfg.demod_power && !o_cond_cfg.demod_skip &&
         win_active[0] && !win_active[1] && !win_active[2])
        |=> o_demod_factor == sdc_pkg::SDC_FACTOR_POS;
    endproperty
    a_pos_factor: assert property (p_pos_factor) // RL3
        else $error("positive window did not give plus one");

    property p_neg_factor;
        (i_seq.running && o_cond_cfg.demod_power && !o_cond_cfg.demod_skip &&
         !win_active[0] && (win_active[1] || win_active[2]))
        |=> o_demod_factor == sdc_pkg::SDC_FACTOR_NEG;
    endproperty
    a_neg_factor: assert property (p_neg_factor) // RL3
        else $error("negative window did not give minus one");

    property p_subs_fire;
        (i_seq.running && !seq_start && i_seq.iter_start &&
         subs_cnt_ff == demod_subsample_ratio)
        |=> o_adc_allow && subs_cnt_ff == 8'h00;
    endproperty
    a_subs_fire: assert property (p_subs_fire) // RL5
        else $error("conversion iteration not allowed on count match");

    property p_subs_skip;
        (i_seq.running && !seq_start && i_seq.iter_start &&
         subs_cnt_ff != demod_subsample_ratio) |=> !o_adc_allow;
    endproperty
    a_subs_skip: assert property (p_subs_skip) // RL5
        else $error("conversion allowed on a skipped iteration");

    property p_gain_legal;
        o_cond_cfg.gain_code != sdc_pkg::GAIN_FORBIDDEN;
    endproperty
    a_gain_legal: assert property (p_gain_legal) // RL12
        else $error("forbidden gain code reached the gain stage");

    property p_seq_readback;
        (i_axi_arvalid && o_axi_arready &&
         i_axi_araddr == sdc_pkg::OFS_SEQ_COUNT)
        |=> o_axi_rvalid && o_axi_rdata[31:24] == $past(subs_cnt_ff);
    endproperty
    a_seq_readback: assert property (p_seq_readback) // RL17
        else $error("subsample count readback wrong");

    property p_start_clear;
        (seq_start && !i_seq.iter_start) |=> subs_cnt_ff == 8'h00;
    endproperty
    a_start_clear: assert property (p_start_clear) // RL18
        else $error("subsample counter not cleared at start");

    property p_meas_dac;
        (do_write && wr_addr == sdc_pkg::OFS_EAF_CFG && wr_strb[3])
        |=> o_cond_cfg.measure_dac == $past(wr_data[24]) &&
            o_cond_cfg.sigref_on_dac_buffer == $past(wr_data[25]);
    endproperty
    a_meas_dac: assert property (p_meas_dac) // RL15
        else $error("dac routing bits not taken from write");
endmodule : sdc_ctrl
`default_nettype wire

// *** testbench/sdc_ctrl_bench.sv ***
// self-checking bench for the demodulator control block
`default_nettype none
module sdc_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic                   i_clock, i_reset, adc_done;
    logic                   awvalid, wvalid, bready, arvalid, rready;
    logic [11:0]            awaddr, araddr;
    logic [31:0]            wdata, rd;
    logic [1:0]             rs;
    wire logic              awready, wready, bvalid, arready, rvalid, allow;
    wire logic [1:0]        bresp, rresp;
    wire logic [31:0]       rdata;
    wire logic [1:0]        factor;     // demodulator factor code
    wire sdc_pkg::sdc_cond_cfg_t cfg;
    sdc_pkg::sdc_seq_t      seq;        // sequencer time base stimulus
    int                     mismatches, tests_run;

    sdc_ctrl dut_u (.i_clock(i_clock), .i_reset(i_reset),
        .i_axi_awvalid(awvalid), .o_axi_awready(awready),
        .i_axi_awaddr(awaddr), .i_axi_awprot(3'h0),
        .i_axi_wvalid(wvalid), .o_axi_wready(wready), .i_axi_wdata(wdata),
        .i_axi_wstrb(4'hF), .o_axi_bvalid(bvalid), .i_axi_bready(bready),
        .o_axi_bresp(bresp), .i_axi_arvalid(arvalid),
        .o_axi_arready(arready), .i_axi_araddr(araddr),
        .i_axi_arprot(3'h0), .o_axi_rvalid(rvalid), .i_axi_rready(rready),
        .o_axi_rdata(rdata), .o_axi_rresp(rresp), .i_seq(seq),
        .i_adc_done(adc_done), .o_demod_factor(factor),
        .o_adc_allow(allow), .o_cond_cfg(cfg));

    // 50 ns period clock
    initial begin
        i_clock = 1'b0;
        forever #25 i_clock = ~i_clock;
    end
    // generous limit, tests need well under a thousand cycles
    initial begin
        repeat (3000) @(posedge i_clock);
        mismatches++;
        close_out();
    end
    task automatic chk(input string       nm,
                       input logic [31:0] e,
                       input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    // write both halves together, release each one as it is taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bit ao, wo;
        ao = 0; wo = 0;
        awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
        while (!(ao && wo)) begin
            @(posedge i_clock);
            if (awvalid && awready) begin ao = 1; awvalid <= 0; end
            if (wvalid && wready) begin wo = 1; wvalid <= 0; end
        end
        do @(posedge i_clock); while (!bvalid);
        rs = bresp;
        bready <= 0;
        // let an edge pass so a following call never reassigns bready
        @(posedge i_clock);
    endtask : wr
    // read one word, result left in rd and rs
    task automatic rdw(input logic [11:0] a);
        araddr <= a; arvalid <= 1; rready <= 1;
        do @(posedge i_clock); while (!arready);
        arvalid <= 0;
        do @(posedge i_clock); while (!rvalid);
        rd = rdata; rs = rresp;
        rready <= 0;
        // let an edge pass so a following call never reassigns rready
        @(posedge i_clock);
    endtask : rdw
    task automatic t_regs();
        rdw(12'h084); chk("count", 32'h0000_0000, rd);
        wr(12'h070, 32'hFFFF_FFFF); rdw(12'h070);
        chk("sc", 32'h071F_FFF8, rd);
        // all signal_conditioning_config settings high, gain code kept at zero
        chk("cfg", 32'h0003_FFC0, {14'h0, cfg});
        wr(12'h070, 32'h0000_005D);
        chk("gain", 32'h5, {29'h0, cfg.gain_code});
        chk("dm", 32'h1, {31'h0, cfg.demod_power});
        wr(12'h084, 32'h0000_00FF);
        chk("bresp", 32'h0, {30'h0, rs});
        rdw(12'h084);
        chk("ro", 32'h0, rd);
        wr(12'h000, 32'hFFFF_FFFF);
        chk("ref", 32'h1, {31'h0, cfg.sigref_enable});
        wr(12'h090, 32'hFFFF_FFFF);
        rdw(12'h090);
        chk("eaf", 32'h0307_FFFF, rd);
        chk("dac", 32'h3,
            {30'h0, cfg.sigref_on_dac_buffer, cfg.measure_dac});
        rdw(12'h100); chk("resp", 32'h2, {30'h0, rs});
        $display("registers done");
    endtask : t_regs
    task automatic t_count();
        repeat (3) begin
            adc_done <= 1;
            @(posedge i_clock);
            adc_done <= 0;
            @(posedge i_clock);
        end
        rdw(12'h084); chk("count", 32'h3, rd);
        $display("count done");
    endtask : t_count
    // set time, expect factor after the registered update
    task automatic tm(input logic [15:0] t, input logic [1:0] e);
        seq.time_now <= t; repeat (2) @(posedge i_clock);
        chk("factor", {30'h0, e}, {30'h0, factor});
    endtask : tm
    task automatic t_demod();
        wr(12'h070, 32'h0400_0040);
        seq.positive_window <= {16'h000A, 16'h0014};
        seq.negative_window1 <= {16'h001E, 16'h0028};
        seq.negative_window2 <= {16'h0032, 16'h003C};
        seq.running <= 1;
        tm(16'h000A, 2'h1); tm(16'h0014, 2'h0); tm(16'h0027, 2'h2);
        tm(16'h0032, 2'h2); tm(16'h003C, 2'h0);
        // overlapping windows: the polarity bit picks the winner
        seq.negative_window1 <= {16'h0000, 16'h0014};
        tm(16'h000A, 2'h1);
        wr(12'h070, 32'h0000_0040);
        tm(16'h000A, 2'h2);
        seq.running <= 0; tm(16'h000C, 2'h0);
        $display("demod done");
    endtask : t_demod
    task automatic t_subs();
        wr(12'h070, 32'h0000_4040);
        seq.running <= 1;
        for (int k = 0; k < 7; k++) begin
            seq.iter_start <= 1; @(posedge i_clock);
            seq.iter_start <= 0; @(posedge i_clock);
            chk("allow", {31'h0, k % 3 == 2}, {31'h0, allow});
            if (k == 0) begin
                rdw(12'h080); chk("subs", 32'h0100_0000, rd);
            end
        end
        seq.running <= 0;
        repeat (2) @(posedge i_clock);
        chk("stop", 32'h0, {31'h0, allow});
        // restart with a stale count of one: start must clear it first
        seq.running <= 1;
        seq.iter_start <= 1;
        @(posedge i_clock);
        seq.iter_start <= 0;
        @(posedge i_clock);
        rdw(12'h080);
        chk("restart", 32'h0100_0000, rd);
        seq.running <= 0;
        $display("subsample done");
    endtask : t_subs
    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : close_out
    // main sequence
    initial begin
        i_reset = 1; adc_done = 0; seq = '0; awvalid = 0; wvalid = 0;
        bready = 0; arvalid = 0; rready = 0; awaddr = 0; araddr = 0;
        wdata = 0; mismatches = 0; tests_run = 0;
        repeat (2) @(posedge i_clock);
        i_reset <= 0;
        @(posedge i_clock);
        t_regs(); t_count(); t_demod(); t_subs();
        close_out();
    end
endmodule : sdc_ctrl_bench
`default_nettype wire
